// file: inc/rms_defs.svh
// Purpose: constants of the receiver mode sequencer
// Assumes: 100 MHz system clock, 8-bit registers, 7-bit register address
// Notes: times are kept in their own unit; cycle counts are derived in the top
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH

// register offsets
`define RMS_ADDR_OPMODE 7'h01
`define RMS_ADDR_LISTEN1 7'h0d
`define RMS_ADDR_IDLE_MULT 7'h0e
`define RMS_ADDR_RX_MULT 7'h0f
`define RMS_ADDR_LISTEN3 7'h10
`define RMS_ADDR_RXCFG 7'h11
`define RMS_ADDR_QBW 7'h12
`define RMS_ADDR_BIT_LO 7'h13
`define RMS_ADDR_BIT_HI 7'h14
`define RMS_ADDR_AUTO 7'h15
`define RMS_ADDR_STATUS 7'h16

// operating mode register fields
`define RMS_OP_SEQ_OFF 7
`define RMS_OP_LISTEN_EN 6
`define RMS_OP_CANCEL 5
`define RMS_OP_MODE_HI 4
`define RMS_OP_MODE_LO 2
`define RMS_MODE_SLEEP 3'h0
`define RMS_MODE_STBY 3'h1
`define RMS_MODE_SYNTH 3'h2
`define RMS_MODE_RX 3'h4

// listen and receive configuration fields
`define RMS_L1_UNIT_HI 7
`define RMS_L1_UNIT_LO 6
`define RMS_L1_RULE 3
`define RMS_L3_EXIT_HI 2
`define RMS_L3_EXIT_LO 1
`define RMS_RX_OOK 0
`define RMS_RX_AFC 1
`define RMS_RX_QUICK 2

// reset values
`define RMS_RST_OPMODE 8'h04
`define RMS_RST_LISTEN1 8'h90
`define RMS_RST_IDLE_MULT 8'hf5
`define RMS_RST_RX_MULT 8'h20
`define RMS_RST_LISTEN3 8'h04
`define RMS_RST_RXCFG 8'h00
`define RMS_RST_QBW 8'h04
`define RMS_RST_BIT 16'h0d05

// timing
`define RMS_CLK_NS 10
`define RMS_ANA_NS 10000
`define RMS_FILT_FSK 21
`define RMS_FILT_OOK 34
`define RMS_AFC_BITS 4
`define RMS_LEVEL_BITS 2
`define RMS_RELOCK_PERIODS 5
`define RMS_PLL_BW_KHZ 300
`define RMS_XTAL_WAKE_NS 500000
`define RMS_SYNTH_WAKE_NS 60000
`define RMS_RC_PERIOD_NS 1000
`define RMS_UNIT1_NS 64000
`define RMS_UNIT2_NS 4100000
`define RMS_UNIT3_NS 260000000

`endif

// file: inc/rms_pkg.sv
// Purpose: types of the receiver mode sequencer
// Assumes: nothing beyond the defines header
// Notes: enums carry no codes; the register field codes live in the header
package rms_pkg;

	// chip position inside the wake-up sequence
	typedef enum logic [3:0] {
		ST_SLEEP, ST_STBY_WAIT, ST_STBY, ST_SYNTH_WAIT, ST_SYNTH,
		ST_RX_ANA, ST_RX_FILT, ST_RX_AFC, ST_RX_RELOCK, ST_RX_LEVEL, ST_RX
	} rms_state_t;

	// requested level of the chip
	typedef enum logic [1:0] {MD_SLEEP, MD_STBY, MD_SYNTH, MD_RX} rms_level_t;

	// listen cycling phase
	typedef enum logic [2:0] {
		LP_OFF, LP_IDLE, LP_RX, LP_STAY, LP_WAIT_MODE, LP_WAIT_IDLE, LP_DONE
	} rms_listen_t;

	// demodulator and packet engine flags, same clock
	typedef struct packed {
		logic levelFlag;
		logic patternMatch;
		logic packetComplete;
		logic timeoutFlag;
		logic checkPass;
		logic queueHasBytes;
		logic demodData;
	} rms_evt_t;

endpackage

// file: logic/rms_delay_timer.sv
// Purpose: loadable down counter with a one-cycle done pulse
// Assumes: start and tick come from the same clock domain
// Notes: a zero load counts as one tick so a done always follows a start
`timescale 1ns/1ps
`default_nettype none

module rms_delay_timer #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic start,
	input wire logic [W-1:0] count,
	input wire logic tick,
	// status
	output logic busy,
	output logic done
);

	logic [W-1:0] cnt_q;
	wire lastTick = (cnt_q <= W'(1));

	// restart wins over a running count
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_q <= count;
				busy <= 1'b1;
			end else if (busy && tick) begin
				cnt_q <= cnt_q - W'(1);
				busy <= !lastTick;
				done <= lastTick;
			end
		end
	end

endmodule

`default_nettype wire

// file: logic/rms_sequencer.sv
// Purpose: operating-mode sequencer with listen cycling and automatic modes
// Assumes: flags in evt are on clk; rcClk is a foreign slow clock
// Notes: registers reached over a plain port, read data one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "rms_defs.svh"

// Behaviour
// - sequencer steps sleep, standby, synthesizer, then receive after lock
// - lock pin goes high once the synthesizer has settled
// - receiver-ready pulse when the receive startup completes
// - startup adds 10 us front end plus 21 or 34 quarter-bandwidth periods
// - frequency correction adds four bit periods then five 300 kHz periods
// - quick start drops the two-bit-period level evaluation
// - demodulated data drives the data pin right after receiver ready
// - listen keeps the chip idle and wakes the receiver periodically
// - receiver switches off when the receive window expires unaccepted
// - each phase lasts its 1..255 multiplier times the shared unit
// - unit codes 01, 10, 11 give 64 us, 4.1 ms, 0.26 s
// - rule 0 needs level above limit; rule 1 also needs pattern match
// - exit action 00 stays in receive and stops cycling
// - exit action 01 waits packet or timeout, then enters the mode field
// - exit action 10 waits packet or timeout, resumes idle, discards queue
// - entry and leave triggers together move to and from the between state
// - final state is the mode field at the moment of leaving
// - mode codes 000, 001, 010, 100; listen enable overrides the field
// - sequence disable enters the selected mode directly
module rms_sequencer
	import rms_pkg::*;
#(
	parameter int XTAL_CYC = `RMS_XTAL_WAKE_NS / `RMS_CLK_NS,
	parameter int SYNTH_CYC = `RMS_SYNTH_WAKE_NS / `RMS_CLK_NS,
	parameter int UNIT1_TICKS = `RMS_UNIT1_NS / `RMS_RC_PERIOD_NS,
	parameter int UNIT2_TICKS = `RMS_UNIT2_NS / `RMS_RC_PERIOD_NS,
	parameter int UNIT3_TICKS = `RMS_UNIT3_NS / `RMS_RC_PERIOD_NS
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic rcClk,
	// register port
	input wire logic [6:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	// receive path flags
	input wire rms_pkg::rms_evt_t evt,
	// chip outputs
	output logic receiverReady,
	output logic synthLocked,
	output logic serialData,
	output logic [2:0] chipMode,
	output logic listenIdle,
	output logic queueDiscard
);
	import rms_pkg::*;

	localparam int ANA_CYC = `RMS_ANA_NS / `RMS_CLK_NS;
	localparam int RELOCK_DEN = `RMS_PLL_BW_KHZ * `RMS_CLK_NS;
	localparam int RELOCK_CYC = (`RMS_RELOCK_PERIODS * 1000000 + RELOCK_DEN - 1) / RELOCK_DEN;

	// registers written by software
	logic [7:0] opMode_q, listen1_q, idleMult_q, rxMult_q, listen3_q;
	logic [7:0] rxCfg_q, qbw_q, auto_q;
	logic [15:0] bitCyc_q;
	logic [7:0] rdData_d;

	// sequencer and listen state
	rms_state_t st_q, st_d;
	rms_listen_t lp_q, lp_d;
	logic betweenOn_q, discardPend_q, queuePrev_q;
	logic rcSync1_q, rcSync2_q, rcSync3_q;
	logic seqStart, lstStart;
	logic [31:0] seqLen, lstLen;
	logic seqDone, lstDone;

	// register decode
	wire opWr = regWr && (regAddr == `RMS_ADDR_OPMODE);
	wire seqOff = opMode_q[`RMS_OP_SEQ_OFF];
	wire listenEn = opMode_q[`RMS_OP_LISTEN_EN];
	wire cancelNow = opWr && regWrData[`RMS_OP_CANCEL] && !regWrData[`RMS_OP_LISTEN_EN];
	wire [2:0] modeField = opMode_q[`RMS_OP_MODE_HI:`RMS_OP_MODE_LO];
	wire [1:0] unitCode = listen1_q[`RMS_L1_UNIT_HI:`RMS_L1_UNIT_LO];
	wire acceptRule = listen1_q[`RMS_L1_RULE];
	wire [1:0] exitAct = listen3_q[`RMS_L3_EXIT_HI:`RMS_L3_EXIT_LO];
	wire isOok = rxCfg_q[`RMS_RX_OOK];
	wire afcOn = rxCfg_q[`RMS_RX_AFC];
	wire quickStart = rxCfg_q[`RMS_RX_QUICK];
	wire [2:0] entryTrig = auto_q[7:5];
	wire [2:0] leaveTrig = auto_q[4:2];
	wire [1:0] betweenCode = auto_q[1:0];

	// mode field decode, unused codes taken as standby
	rms_level_t fieldLevel;
	always_comb begin
		unique case (modeField)
			`RMS_MODE_SLEEP: fieldLevel = MD_SLEEP;
			`RMS_MODE_SYNTH: fieldLevel = MD_SYNTH;
			`RMS_MODE_RX: fieldLevel = MD_RX;
			default: fieldLevel = MD_STBY;
		endcase
	end

	// automatic-mode trigger selection
	wire queueFall = queuePrev_q && !evt.queueHasBytes;
	wire [7:0] trigVec = {evt.timeoutFlag, queueFall, evt.queueHasBytes && !queuePrev_q,
		evt.levelFlag, evt.patternMatch, evt.checkPass, evt.packetComplete, 1'b0};
	// both triggers must be set for automatic modes
	wire autoOn = (entryTrig != 3'h0) && (leaveTrig != 3'h0) && !listenEn;
	wire entryHit = autoOn && trigVec[entryTrig];
	wire leaveHit = autoOn && trigVec[leaveTrig];

	// target follows the live mode field outside the between state
	wire rms_level_t autoLevel = betweenOn_q ? rms_level_t'(betweenCode) : fieldLevel;

	// target level; listen phase overrides the field
	rms_level_t tgt;
	always_comb begin
		unique case (lp_q)
			LP_OFF: tgt = autoLevel;
			// idle keeps only the slow oscillator
			LP_IDLE: tgt = MD_SLEEP;
			LP_DONE: tgt = fieldLevel;
			default: tgt = MD_RX;
		endcase
	end

	// startup step lengths in clk cycles
	wire [31:0] bitLen = {16'h0000, bitCyc_q};
	// filter delay scales the quarter-bandwidth period
	wire [31:0] filtLen = 32'(qbw_q) * (isOok ? 32'(`RMS_FILT_OOK) : 32'(`RMS_FILT_FSK));
	wire [31:0] afcLen = 32'(bitLen * `RMS_AFC_BITS);
	wire [31:0] levelLen = 32'(bitLen * `RMS_LEVEL_BITS);

	// settled state for a level, used when stepping down or going direct
	function automatic rms_state_t settled(input rms_level_t lvl);
		unique case (lvl)
			MD_SLEEP: settled = ST_SLEEP;
			MD_STBY: settled = ST_STBY;
			MD_SYNTH: settled = ST_SYNTH;
			default: settled = ST_RX;
		endcase
	endfunction

	// wake-up sequencer; wait states ignore the target so requests queue
	always_comb begin
		st_d = st_q;
		seqStart = 1'b0;
		seqLen = 32'h0000_0001;
		unique case (st_q)
			ST_SLEEP: begin
				// direct entry when sequencing is off
				if (tgt != MD_SLEEP && seqOff) begin
					st_d = settled(tgt);
				end else if (tgt != MD_SLEEP) begin
					st_d = ST_STBY_WAIT;
					seqStart = 1'b1;
					seqLen = 32'(XTAL_CYC);
				end
			end
			// step finishes before the target is looked at again
			ST_STBY_WAIT: if (seqDone) st_d = ST_STBY;
			ST_STBY: begin
				if (tgt == MD_SLEEP || seqOff) begin
					st_d = settled(tgt);
				end else if (tgt != MD_STBY) begin
					st_d = ST_SYNTH_WAIT;
					seqStart = 1'b1;
					seqLen = 32'(SYNTH_CYC);
				end
			end
			ST_SYNTH_WAIT: if (seqDone) st_d = ST_SYNTH;
			ST_SYNTH: begin
				if (tgt != MD_RX || seqOff) begin
					st_d = settled(tgt);
				end else begin
					st_d = ST_RX_ANA;
					seqStart = 1'b1;
					seqLen = 32'(ANA_CYC);
				end
			end
			ST_RX_ANA: begin
				if (seqDone) begin
					st_d = ST_RX_FILT;
					seqStart = 1'b1;
					seqLen = filtLen;
				end
			end
			ST_RX_FILT: begin
				if (seqDone && afcOn) begin
					st_d = ST_RX_AFC;
					seqStart = 1'b1;
					seqLen = afcLen;
				end else if (seqDone && quickStart) begin
					st_d = ST_RX;
				end else if (seqDone) begin
					st_d = ST_RX_LEVEL;
					seqStart = 1'b1;
					seqLen = levelLen;
				end
			end
			ST_RX_AFC: begin
				if (seqDone) begin
					st_d = ST_RX_RELOCK;
					seqStart = 1'b1;
					seqLen = 32'(RELOCK_CYC);
				end
			end
			ST_RX_RELOCK: begin
				if (seqDone && quickStart) begin
					st_d = ST_RX;
				end else if (seqDone) begin
					st_d = ST_RX_LEVEL;
					seqStart = 1'b1;
					seqLen = levelLen;
				end
			end
			ST_RX_LEVEL: if (seqDone) st_d = ST_RX;
			// leaving receive for the synthesizer keeps lock
			ST_RX: if (tgt != MD_RX) st_d = settled(tgt);
			default: st_d = ST_SLEEP;
		endcase
	end

	// listen phase decisions
	// acceptance rule
	wire accepted = evt.levelFlag && (!acceptRule || evt.patternMatch);
	wire pktEnd = evt.packetComplete || evt.timeoutFlag;
	// resolution unit; reserved code 00 falls back to the shortest
	wire [31:0] unitTicks = (unitCode == 2'h3) ? 32'(UNIT3_TICKS) :
		(unitCode == 2'h2) ? 32'(UNIT2_TICKS) : 32'(UNIT1_TICKS);
	// phase length is multiplier times unit, zero multiplier as one
	wire [7:0] idleK = (idleMult_q == 8'h00) ? 8'h01 : idleMult_q;
	wire [7:0] rxK = (rxMult_q == 8'h00) ? 8'h01 : rxMult_q;
	wire [31:0] idleLen = 32'(unitTicks * 32'(idleK));
	wire [31:0] rxLen = 32'(unitTicks * 32'(rxK));

	always_comb begin
		lp_d = lp_q;
		lstStart = 1'b0;
		lstLen = idleLen;
		unique case (lp_q)
			LP_OFF: begin
				if (listenEn) begin
					lp_d = LP_IDLE;
					lstStart = 1'b1;
				end
			end
			LP_IDLE: begin
				// receive window loaded at its start
				if (lstDone && listenEn) begin
					lp_d = LP_RX;
					lstStart = 1'b1;
					lstLen = rxLen;
				end else if (lstDone) begin
					lp_d = LP_OFF;
				end
			end
			LP_RX: begin
				if (accepted) begin
					unique case (exitAct)
						2'h0: lp_d = LP_STAY;
						2'h1: lp_d = LP_WAIT_MODE;
						default: lp_d = LP_WAIT_IDLE;
					endcase
				end else if (lstDone && listenEn) begin
					// window over, receiver off until next period
					lp_d = LP_IDLE;
					lstStart = 1'b1;
				end else if (lstDone) begin
					lp_d = LP_OFF;
				end
			end
			LP_WAIT_MODE: if (pktEnd) lp_d = LP_DONE;
			LP_WAIT_IDLE: begin
				if (pktEnd) begin
					lp_d = LP_IDLE;
					lstStart = 1'b1;
				end
			end
			default: if (!listenEn) lp_d = LP_OFF;
		endcase
		// cancel ends any phase at once
		if (cancelNow) begin
			lp_d = LP_OFF;
			lstStart = 1'b0;
		end
	end

	// register writes; cancel bit never stored
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			opMode_q <= `RMS_RST_OPMODE;
			listen1_q <= `RMS_RST_LISTEN1;
			idleMult_q <= `RMS_RST_IDLE_MULT;
			rxMult_q <= `RMS_RST_RX_MULT;
			listen3_q <= `RMS_RST_LISTEN3;
			rxCfg_q <= `RMS_RST_RXCFG;
			qbw_q <= `RMS_RST_QBW;
			bitCyc_q <= `RMS_RST_BIT;
			auto_q <= 8'h00;
		end else if (regWr) begin
			unique case (regAddr)
				`RMS_ADDR_OPMODE: opMode_q <= regWrData & 8'hdc;
				`RMS_ADDR_LISTEN1: listen1_q <= regWrData;
				`RMS_ADDR_IDLE_MULT: idleMult_q <= regWrData;
				`RMS_ADDR_RX_MULT: rxMult_q <= regWrData;
				`RMS_ADDR_LISTEN3: listen3_q <= regWrData;
				`RMS_ADDR_RXCFG: rxCfg_q <= regWrData;
				`RMS_ADDR_QBW: qbw_q <= regWrData;
				`RMS_ADDR_BIT_LO: bitCyc_q[7:0] <= regWrData;
				`RMS_ADDR_BIT_HI: bitCyc_q[15:8] <= regWrData;
				`RMS_ADDR_AUTO: auto_q <= regWrData;
				default: ;
			endcase
		end
	end

	// read mux; status shows sequencer state and listen phase
	always_comb begin
		unique case (regAddr)
			`RMS_ADDR_OPMODE: rdData_d = opMode_q;
			`RMS_ADDR_LISTEN1: rdData_d = listen1_q;
			`RMS_ADDR_IDLE_MULT: rdData_d = idleMult_q;
			`RMS_ADDR_RX_MULT: rdData_d = rxMult_q;
			`RMS_ADDR_LISTEN3: rdData_d = listen3_q;
			`RMS_ADDR_RXCFG: rdData_d = rxCfg_q;
			`RMS_ADDR_QBW: rdData_d = qbw_q;
			`RMS_ADDR_BIT_LO: rdData_d = bitCyc_q[7:0];
			`RMS_ADDR_BIT_HI: rdData_d = bitCyc_q[15:8];
			`RMS_ADDR_AUTO: rdData_d = auto_q;
			`RMS_ADDR_STATUS: rdData_d = {st_q, 1'b0, lp_q};
			default: rdData_d = 8'h00;
		endcase
	end

	// slow oscillator crossing; third stage only feeds the edge detect
	always_ff @(posedge clk) begin
		rcSync1_q <= rcClk;
		rcSync2_q <= rcSync1_q;
		rcSync3_q <= rcSync2_q;
	end
	wire rcTick = rcSync2_q && !rcSync3_q;

	// step and phase timers
	rms_delay_timer #(.W(32)) seqTimer (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(seqStart),
		.count(seqLen),
		.tick(1'b1),
		.busy(),
		.done(seqDone)
	);
	rms_delay_timer #(.W(32)) lstTimer (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(lstStart),
		.count(lstLen),
		.tick(rcTick),
		.busy(),
		.done(lstDone)
	);

	// state, auto flag and discard tracking
	wire enterRx = (lp_q == LP_IDLE) && (lp_d == LP_RX);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= ST_SLEEP;
			lp_q <= LP_OFF;
			betweenOn_q <= 1'b0;
			discardPend_q <= 1'b0;
			queuePrev_q <= 1'b0;
		end else begin
			st_q <= st_d;
			lp_q <= lp_d;
			queuePrev_q <= evt.queueHasBytes;
			// enter on entry trigger, leave on leave trigger
			if (!autoOn || (betweenOn_q && leaveHit)) begin
				betweenOn_q <= 1'b0;
			end else if (entryHit) begin
				betweenOn_q <= 1'b1;
			end
			// a new packet end wins over a cancel in the same cycle
			if ((lp_q == LP_WAIT_IDLE) && pktEnd) begin
				discardPend_q <= 1'b1;
			end else if (enterRx || cancelNow) begin
				discardPend_q <= 1'b0;
			end
		end
	end

	// registered outputs
	wire rxReach = (st_d == ST_RX) && (st_q != ST_RX);
	wire lockNext = (st_d == ST_SYNTH) || (st_d >= ST_RX_ANA);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regRdData <= 8'h00;
			receiverReady <= 1'b0;
			synthLocked <= 1'b0;
			serialData <= 1'b0;
			chipMode <= `RMS_MODE_SLEEP;
			listenIdle <= 1'b0;
			queueDiscard <= 1'b0;
		end else begin
			regRdData <= regRd ? rdData_d : 8'h00;
			receiverReady <= rxReach;
			synthLocked <= lockNext;
			// data follows the demodulator once ready
			serialData <= (st_q == ST_RX) && (st_d == ST_RX) && evt.demodData; // quiet on the leaving cycle
			chipMode <= (st_d == ST_SLEEP) ? `RMS_MODE_SLEEP :
				(st_d <= ST_STBY) ? `RMS_MODE_STBY :
				(st_d <= ST_SYNTH) ? `RMS_MODE_SYNTH : `RMS_MODE_RX;
			listenIdle <= (lp_d == LP_IDLE);
			queueDiscard <= enterRx && discardPend_q;
		end
	end

endmodule

`default_nettype wire

// file: bench/rms_sequencer_assertions.sv
// Purpose: port-level checks of the mode sequencer
// Assumes: bound into every rms_sequencer instance
// Notes: startup time is checked as a lower bound, register values are hidden
`timescale 1ns/1ps
`default_nettype none

module rms_sequencer_chk
	import rms_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// receive path flags
	input wire rms_pkg::rms_evt_t evt,
	// chip outputs
	input wire logic receiverReady,
	input wire logic synthLocked,
	input wire logic serialData,
	input wire logic [2:0] chipMode,
	input wire logic listenIdle,
	input wire logic queueDiscard
);
	import rms_pkg::*;
	logic [10:0] lockCnt_q;
	logic [11:0] idleWait_q;

	// cycles spent locked, saturating so it cannot wrap
	always_ff @(posedge clk) begin
		if (sys_rst || !synthLocked)
			lockCnt_q <= 11'h000;
		else if (lockCnt_q != 11'h7ff)
			lockCnt_q <= lockCnt_q + 11'h001;
	end

	// cycles in listen idle with the chip not yet asleep; a range this long would unroll badly
	always_ff @(posedge clk) begin
		if (sys_rst || !listenIdle || chipMode == 3'h0)
			idleWait_q <= 12'h000;
		else if (idleWait_q != 12'hfff)
			idleWait_q <= idleWait_q + 12'h001;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// settled receive with the loop locked
	sequence rxSettled;
		synthLocked && chipMode == 3'h4;
	endsequence

	chk_ready_pulse: assert property (receiverReady |=> !receiverReady)
		else $error("ready pulse longer than one cycle");
	chk_ready_state: assert property (receiverReady |-> rxSettled)
		else $error("ready outside locked receive");
	chk_lock_time: assert property (receiverReady && $past(chipMode) == 3'h4 |-> lockCnt_q >= 11'h3e8)
		else $error("ready before the front end delay");
	chk_lock_mode: assert property (synthLocked |-> chipMode == 3'h2 || chipMode == 3'h4)
		else $error("lock shown outside synth or receive");
	chk_lock_synth: assert property ($rose(synthLocked) && !receiverReady |-> chipMode == 3'h2)
		else $error("lock rose outside synth mode");
	chk_mode_legal: assert property (chipMode inside {3'h0, 3'h1, 3'h2, 3'h4})
		else $error("illegal chip mode code");
	chk_data_follow: assert property (serialData |-> $past(evt.demodData) ##0 rxSettled)
		else $error("data pin not following demodulator");
	chk_discard_pulse: assert property (queueDiscard |=> !queueDiscard)
		else $error("discard pulse longer than one cycle");
	chk_idle_sleep: assert property (idleWait_q <= 12'h7d0)
		else $error("listen idle without sleeping");
endmodule

bind rms_sequencer rms_sequencer_chk u_rms_sequencer_chk (.clk(clk), .sys_rst(sys_rst), .evt(evt),
	.receiverReady(receiverReady), .synthLocked(synthLocked), .serialData(serialData),
	.chipMode(chipMode), .listenIdle(listenIdle), .queueDiscard(queueDiscard));

`default_nettype wire

// file: bench/rms_rx_model.sv
// Purpose: demodulator and packet engine flags seen by the sequencer
// Assumes: bench commands carrier, sync and end events on clk
// Notes: data toggles every cycle so a stale data pin shows at once
`timescale 1ns/1ps
`default_nettype none

module rms_rx_model
	import rms_pkg::*;
#(
	parameter int BIT_CYC = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bench commands
	input wire logic carrier,
	input wire logic syncOn,
	input wire logic pktDone,
	input wire logic timeOut,
	// chip side
	input wire logic receiverReady,
	input wire logic [2:0] chipMode,
	output rms_pkg::rms_evt_t evt
);
	int preCnt;
	logic demod_q;

	always_ff @(posedge clk) begin
		if (sys_rst || chipMode != 3'h4)
			preCnt <= 0;
		else if (receiverReady)
			preCnt <= 1;
		else if (preCnt != 0 && preCnt < 12 * BIT_CYC)
			preCnt <= preCnt + 1;
	end

	// changing pattern on the data line
	always_ff @(posedge clk) begin
		demod_q <= sys_rst ? 1'b0 : !demod_q;
	end

	// match only after 12 preamble bits
	assign evt = {carrier, syncOn && preCnt >= 12 * BIT_CYC, pktDone, timeOut, 1'b0, 1'b0, demod_q};
endmodule

`default_nettype wire

// file: bench/rms_sequencer_tb.sv
// Purpose: register-driven tests of the mode sequencer
// Assumes: shortened wake and unit counts, bit period 16 cycles
// Notes: startup windows allow a few cycles of hand-off slack
`timescale 1ns/1ps
`default_nettype none
`include "rms_defs.svh"

module rms_sequencer_tb;
	import rms_pkg::*;
	localparam int BITC = 16;
	localparam logic [6:0] OPM = `RMS_ADDR_OPMODE;
	localparam logic [6:0] RA [10] = '{7'h01, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h20};
	localparam logic [7:0] RV [10] = '{8'h04, 8'h90, 8'hf5, 8'h20, 8'h04, 8'h00, 8'h04, 8'h05, 8'h0d, 8'h00};
	localparam logic [7:0] CFG [5] = '{8'h07, 8'h02, 8'h04, 8'h01, 8'h00};
	logic clk, sys_rst, rcClk, regWr, regRd, carrier, syncOn, pktDone, timeOut, prevData;
	logic [6:0] regAddr;
	logic [7:0] regWrData, regRdData, rdVal;
	logic receiverReady, synthLocked, serialData, listenIdle, queueDiscard;
	logic [2:0] chipMode;
	rms_evt_t evt;
	int n_mismatch, comparisons, waited, expCyc;

	rms_sequencer #(.XTAL_CYC(20), .SYNTH_CYC(20), .UNIT1_TICKS(2), .UNIT2_TICKS(3), .UNIT3_TICKS(4))
	u_rms_sequencer (.clk(clk), .sys_rst(sys_rst), .rcClk(rcClk), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .evt(evt),
		.receiverReady(receiverReady), .synthLocked(synthLocked), .serialData(serialData),
		.chipMode(chipMode), .listenIdle(listenIdle), .queueDiscard(queueDiscard));
	rms_rx_model #(.BIT_CYC(BITC)) u_rms_rx_model (.clk(clk), .sys_rst(sys_rst), .carrier(carrier),
		.syncOn(syncOn), .pktDone(pktDone), .timeOut(timeOut), .receiverReady(receiverReady),
		.chipMode(chipMode), .evt(evt));

	// system clock and an unrelated 1 us oscillator
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rcClk = 1'b0;
		#3.7;
		forever #500 rcClk = ~rcClk;
	end

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		d = regRdData;
	endtask

	task automatic pulse(input logic tmo);
		@(posedge clk);
		if (tmo)
			timeOut <= 1'b1;
		else
			pktDone <= 1'b1;
		@(posedge clk);
		timeOut <= 1'b0;
		pktDone <= 1'b0;
	endtask

	function automatic logic [2:0] pick(input int sel);
		case (sel)
			0: return chipMode;
			1: return {2'b00, receiverReady};
			2: return {2'b00, listenIdle};
			default: return {2'b00, queueDiscard};
		endcase
	endfunction

	// sampled on the falling edge, away from the launching edge
	task automatic waitsig(input int sel, input logic [2:0] v, input int lim);
		waited = 0;
		do begin
			@(negedge clk);
			waited++;
			if (waited > lim) begin
				n_mismatch++;
				$display("unexpected wait on output %0d: expected %0h seen %0h", sel, v, pick(sel));
				end_sim();
			end
		end while (pick(sel) !== v);
	endtask

	// front end, filter, correction and relock (1667 + 1), level steps
	function automatic int rxStart(input logic [7:0] cfg);
		rxStart = `RMS_ANA_NS / `RMS_CLK_NS + 1 + 4 * (cfg[0] ? `RMS_FILT_OOK : `RMS_FILT_FSK) + 1;
		if (cfg[1])
			rxStart += 4 * BITC + 1 + 1668;
		if (!cfg[2])
			rxStart += 2 * BITC + 1;
	endfunction

	function automatic logic inWin(input int e);
		return waited >= e - 2 && waited <= e + 4;
	endfunction

	initial begin
		{regWr, regRd, carrier, syncOn, pktDone, timeOut} = 6'h00;
		regAddr = 7'h00;
		regWrData = 8'h00;
		sys_rst = 1'b1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			rd(RA[i], rdVal);
			chk("reset value", rdVal, RV[i]);
		end
		wr(`RMS_ADDR_BIT_LO, 8'h10);
		wr(`RMS_ADDR_BIT_HI, 8'h00);
		wr(OPM, 8'h10);
		waitsig(1, 3'h1, 20000);
		chk("wake to rx", inWin(21 + rxStart(8'h00)), 1'b1);
		for (int i = 0; i < 4; i++) begin
			prevData = evt.demodData;
			@(negedge clk);
			chk("data pin", serialData, prevData);
		end
		foreach (CFG[i]) begin
			wr(OPM, 8'h08);
			waitsig(0, 3'h2, 10);
			chk("lock on hop", synthLocked, 1'b1);
			wr(`RMS_ADDR_RXCFG, CFG[i]);
			wr(OPM, 8'h10);
			waitsig(1, 3'h1, 20000);
			chk("startup", inWin(rxStart(CFG[i])), 1'b1);
		end
		wr(OPM, 8'h80);
		waitsig(0, 3'h0, 4);
		wr(OPM, 8'h88);
		waitsig(0, 3'h2, 4);
		chk("direct synth", synthLocked, 1'b1);
		wr(OPM, 8'h08);
		wr(`RMS_ADDR_IDLE_MULT, 8'h03);
		wr(`RMS_ADDR_RX_MULT, 8'h14);
		for (int u = 1; u < 4; u++) begin
			wr(`RMS_ADDR_LISTEN1, 8'(u << 6));
			wr(OPM, 8'h40);
			waitsig(2, 3'h1, 20000);
			waitsig(2, 3'h0, 5000);
			expCyc = 300 * (u + 1);
			chk("idle length", waited >= expCyc - 100 && waited <= expCyc + 300, 1'b1);
			waitsig(1, 3'h1, 4000);
			waitsig(2, 3'h1, 12000);
			repeat (3) @(negedge clk);
			chk("rx off unaccepted", chipMode, 3'h0);
			wr(OPM, 8'h24);
			waitsig(0, 3'h1, 3000);
		end
		wr(`RMS_ADDR_LISTEN1, 8'h48);
		carrier <= 1'b1;
		wr(OPM, 8'h40);
		waitsig(1, 3'h1, 20000);
		waitsig(2, 3'h1, 12000);
		chk("no sync refused", waited >= 800, 1'b1);
		wr(OPM, 8'h24);
		syncOn <= 1'b1;
		for (int ex = 0; ex < 3; ex++) begin
			wr(`RMS_ADDR_LISTEN3, 8'(ex << 1));
			wr(OPM, 8'h44);
			waitsig(1, 3'h1, 20000);
			// room for the 12 preamble bits before the match
			repeat (400) @(posedge clk);
			pulse(ex == 1);
			if (ex == 0) begin
				repeat (6000) @(negedge clk);
				chk("stay rx", {listenIdle, chipMode}, 4'h4);
			end else if (ex == 1) begin
				waitsig(0, 3'h1, 100);
				chk("mode field after end", listenIdle, 1'b0);
			end else begin
				waitsig(2, 3'h1, 100);
				waitsig(3, 3'h1, 5000);
				// the wake-up step shows one cycle after the discard pulse
				@(negedge clk);
				chk("discard on wake", chipMode, 3'h1);
			end
			wr(OPM, 8'h24);
			waitsig(0, 3'h1, 3000);
		end
		@(posedge clk);
		{carrier, syncOn} <= 2'b00;
		wr(OPM, 8'h10);
		waitsig(1, 3'h1, 20000);
		wr(`RMS_ADDR_AUTO, 8'h3c);
		pulse(1'b0);
		waitsig(0, 3'h0, 100);
		wr(OPM, 8'h08);
		pulse(1'b1);
		waitsig(0, 3'h2, 200);
		// past the synth wait, a stale receive target would show 100 here
		repeat (30) @(negedge clk);
		chk("final from mode field", chipMode, 3'h2);
		wr(`RMS_ADDR_AUTO, 8'h00);
		rd(OPM, rdVal);
		chk("mode readback", rdVal, 8'h08);
		end_sim();
	end
endmodule

`default_nettype wire
